// ===== hw/selfid_status_iso_mask_high.sv
// How it works
// RULE1 - Error during reception sets fault flag bit 31
// RULE2 - Fault set means buffer contents undefined
// RULE3 - Clean reception end clears the fault flag
// RULE4 - Hardware faults and host write errors count
// RULE5 - Each bus reset steps the 8-bit tally
// RULE6 - Tally wraps from 255 to zero
// RULE7 - Bits 10..2 count written buffer quadlets
// RULE8 - Quadlet tally zeroed when reception starts
// RULE9 - Bits 30..24 read as zero
// RULE10 - Bits 15..11 read as zero
// RULE11 - Bits 1..0 read as zero
// RULE12 - Upper mask gates upper channel packets
// RULE13 - Mask bit n enables channel 32+n
// RULE14 - Set and clear addresses read the mask
// RULE15 - Ones set or clear, zeros keep
// RULE16 - Software writes to status word ignored
`timescale 1ns/100ps
`default_nettype none
`include "selfid_params.svh"
module selfid_status_iso_mask_high
  import selfid_pkg::*;
(
  input  wire logic        MCLK,         // 100 MHz clock
  input  wire logic        RST_N,        // Synchronous reset, active low
  input  wire logic [7:0]  ADDR,         // Register byte address
  input  wire logic [31:0] WDATA,        // Write data
  input  wire logic        WR,           // Write strobe
  input  wire logic        RD,           // Read strobe
  output logic      [31:0] RDATA,        // Read data, cycle after RD
  input  wire logic        BUS_RESET,    // Bus reset detected
  input  wire logic        RX_START,     // Self-ID reception begins
  input  wire logic        RX_QUAD,      // Quadlet written to buffer
  input  wire logic        RX_DONE,      // Self-ID reception ends
  input  wire logic        RX_HW_ERR,    // Internal hardware fault
  input  wire logic        RX_HOST_ERR,  // Host memory write failed
  input  wire logic        ISO_VALID,    // Isochronous packet offered
  input  wire logic [5:0]  ISO_CHANNEL,  // Its channel number
  output logic             ISO_ACCEPT,   // Packet accepted
  output logic             BUF_VALID,    // Buffer contents usable
  output logic             IRQ           // Interrupt, active high
);

  bank_state_type b_q;  // Registered state
  bank_state_type b_d;  // Next state

  // Link to the status tracker
  selfid_track_if trk ();

  // Status field keeper
  selfid_tracker u_tracker (
    .clk   (MCLK),
    .rst_n (RST_N),
    .trk   (trk)
  );

  // Hardware and host errors both mark the reception
  assign trk.rx_err    = RX_HW_ERR | RX_HOST_ERR;  // RULE4
  assign trk.bus_reset = BUS_RESET;
  assign trk.rx_start  = RX_START;
  assign trk.rx_quad   = RX_QUAD;
  assign trk.rx_done   = RX_DONE;

  // Outputs come straight from the state register
  assign RDATA      = b_q.rdata;
  assign ISO_ACCEPT = b_q.iso_accept;
  assign BUF_VALID  = b_q.buf_valid;
  assign IRQ        = b_q.irq;

  // Pack the status word with zeros in unused bits
  function automatic logic [31:0] status_word(
    input logic               fault,
    input logic [`GEN_W-1:0]  gen,
    input logic [`QUAD_W-1:0] tally
  );
    logic [31:0] w;
    w = 32'h0000_0000;  // RULE9 RULE10 RULE11
    w[`FAULT_POS] = fault;  // RULE1
    w[`GEN_LSB +: `GEN_W] = gen;  // RULE5
    w[`QUAD_LSB +: `QUAD_W] = tally;  // RULE7
    return w;
  endfunction : status_word

  // Either address of the upper channel mask
  function automatic logic is_mask_addr(input logic [7:0] a);
    return (a == `OFF_MASK_SET) || (a == `OFF_MASK_CLEAR);
  endfunction : is_mask_addr

  // Next state of the bank
  always_comb begin
    logic [`EV_W-1:0] ev_set;  // Events seen this cycle
    ev_set = `EVENT_RESET;
    b_d    = b_q;

    // Event sources
    ev_set[`EV_BUS_RESET] = BUS_RESET;
    ev_set[`EV_RX_DONE]   = trk.done_hit;
    ev_set[`EV_FAULT]     = trk.err_hit;

    // Register writes
    if (WR) begin
      if (ADDR == `OFF_MASK_SET) begin
        b_d.mask = b_q.mask | WDATA;  // RULE15
      end else if (ADDR == `OFF_MASK_CLEAR) begin
        b_d.mask = b_q.mask & ~WDATA;  // RULE15
      end else if (ADDR == `OFF_EVENT_STATUS) begin
        // Write one to clear
        b_d.ev_status = b_q.ev_status & ~WDATA[`EV_W-1:0];
      end else if (ADDR == `OFF_EVENT_MASK) begin
        b_d.ev_mask = WDATA[`EV_W-1:0];
      end else begin
        // Status word and unmapped: no effect
        b_d.mask = b_q.mask;  // RULE16
      end
    end

    // New events win over a clear in the same cycle
    b_d.ev_status = b_d.ev_status | ev_set;

    // Register reads, data stand one cycle later
    b_d.rdata = 32'h0000_0000;
    if (RD) begin
      if (ADDR == `OFF_NODE_REPORT) begin
        b_d.rdata = status_word(trk.fault, trk.gen, trk.tally);
      end else if (is_mask_addr(ADDR)) begin
        b_d.rdata = b_q.mask;  // RULE14
      end else if (ADDR == `OFF_EVENT_STATUS) begin
        b_d.rdata = {{(32-`EV_W){1'b0}}, b_q.ev_status};
      end else if (ADDR == `OFF_EVENT_MASK) begin
        b_d.rdata = {{(32-`EV_W){1'b0}}, b_q.ev_mask};
      end else begin
        // Unmapped reads as zero
        b_d.rdata = 32'h0000_0000;
      end
    end

    // Upper channel gate; lower channels are not ours
    b_d.iso_accept = ISO_VALID && ISO_CHANNEL[5]
                     && b_q.mask[ISO_CHANNEL[4:0]];  // RULE12 RULE13

    // Buffer usable while the fault flag is clear and no reception is running
    b_d.buf_valid = !trk.fault && !trk.receiving;  // RULE2

    // Level interrupt from unmasked sticky events
    b_d.irq = |(b_d.ev_status & b_d.ev_mask);
  end

  // State register, synchronous reset
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      b_q <= '{mask: `MASK_RESET, ev_status: `EVENT_RESET,
               ev_mask: `EVENT_RESET, rdata: 32'h0000_0000,
               irq: 1'b0, iso_accept: 1'b0, buf_valid: 1'b0};
    end else begin
      b_q <= b_d;
    end
  end

  chk_status_zeros: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE9
    RD && ADDR == `OFF_NODE_REPORT
    |=> RDATA[30:24] == 7'h00 && RDATA[15:11] == 5'h00 && RDATA[1:0] == 2'h0)
    else $error("reserved status bits not zero");
  chk_status_fields: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE7
    RD && ADDR == `OFF_NODE_REPORT
    |=> RDATA[31] == $past(trk.fault) && RDATA[23:16] == $past(trk.gen)
        && RDATA[10:2] == $past(trk.tally))
    else $error("status word fields misplaced");
  chk_mask_read: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE14
    RD && is_mask_addr(ADDR) |=> RDATA == $past(b_q.mask))
    else $error("mask read mismatch");
  chk_mask_set: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE15
    WR && ADDR == `OFF_MASK_SET |=> b_q.mask == ($past(b_q.mask) | $past(WDATA)))
    else $error("mask set wrong");
  chk_mask_clear: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE15
    WR && ADDR == `OFF_MASK_CLEAR |=> b_q.mask == ($past(b_q.mask) & ~$past(WDATA)))
    else $error("mask clear wrong");
  chk_iso_gate: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE13
    ISO_VALID && ISO_CHANNEL[5]
    |=> ISO_ACCEPT == $past(b_q.mask[ISO_CHANNEL[4:0]]))
    else $error("channel gate wrong");
  chk_iso_lower: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE12
    !ISO_CHANNEL[5] |=> !ISO_ACCEPT)
    else $error("lower channel accepted");
  chk_status_write: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE16
    WR && ADDR == `OFF_NODE_REPORT && !BUS_RESET |=> trk.gen == $past(trk.gen))
    else $error("status write had effect");
  chk_buf_fault: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE2
    trk.fault |=> !BUF_VALID)
    else $error("buffer valid despite fault");
  chk_irq_level: assert property (@(posedge MCLK) disable iff (!RST_N)
    ##1 IRQ == |(b_q.ev_status & b_q.ev_mask))
    else $error("interrupt level wrong");
endmodule : selfid_status_iso_mask_high
`default_nettype wire

// ===== inc/selfid_params.svh
`ifndef SELFID_PARAMS_SVH
`define SELFID_PARAMS_SVH
// Register offsets (byte addresses)
`define OFF_NODE_REPORT   8'h68
`define OFF_MASK_SET      8'h70
`define OFF_MASK_CLEAR    8'h74
`define OFF_EVENT_STATUS  8'hA0
`define OFF_EVENT_MASK    8'hA4
// Status word field positions
`define FAULT_POS         31
`define GEN_LSB           16
`define GEN_W             8
`define QUAD_LSB          2
`define QUAD_W            9
// Event bits and count
`define EV_W              3
`define EV_BUS_RESET      0
`define EV_RX_DONE        1
`define EV_FAULT          2
// Reset values and quadlet tally limit
`define MASK_RESET        32'h0000_0000
`define EVENT_RESET       3'h0
`define GEN_RESET         8'h00
`define QUAD_RESET        9'h000
`define QUAD_MAX          9'h1FF
`endif

// ===== inc/selfid_pkg.sv
`include "selfid_params.svh"
package selfid_pkg;
  // State of the reception tracker
  typedef struct packed {
    logic                 fault;      // Error flag of latest reception
    logic                 err_seen;   // Error met in running reception
    logic                 receiving;  // Reception in progress
    logic [`GEN_W-1:0]    gen;        // Bus reset tally
    logic [`QUAD_W-1:0]   tally;      // Quadlets written this round
  } tracker_state_type;
  // State of the register bank
  typedef struct packed {
    logic [31:0]          mask;       // Upper channel enables
    logic [`EV_W-1:0]     ev_status;  // Sticky events
    logic [`EV_W-1:0]     ev_mask;    // Event enables
    logic [31:0]          rdata;      // Read data
    logic                 irq;        // Interrupt level
    logic                 iso_accept; // Packet accept decision
    logic                 buf_valid;  // Buffer contents defined
  } bank_state_type;
endpackage : selfid_pkg

// ===== inc/selfid_track_if.sv
`timescale 1ns/100ps
`default_nettype none
`include "selfid_params.svh"
interface selfid_track_if;
  logic                bus_reset;  // Bus reset seen
  logic                rx_start;   // Reception begins
  logic                rx_quad;    // Quadlet written to buffer
  logic                rx_done;    // Reception ends
  logic                rx_err;     // Hardware or host write error
  logic                fault;      // Error flag
  logic                receiving;  // Reception in progress
  logic                err_hit;    // Error taken this cycle
  logic                done_hit;   // End taken this cycle
  logic [`GEN_W-1:0]   gen;        // Bus reset tally
  logic [`QUAD_W-1:0]  tally;      // Quadlet tally
  // Bank side drives events
  modport bank (output bus_reset, rx_start, rx_quad, rx_done, rx_err,
                input fault, receiving, err_hit, done_hit, gen, tally);
  // Tracker side keeps the status fields
  modport tracker (input bus_reset, rx_start, rx_quad, rx_done, rx_err,
                   output fault, receiving, err_hit, done_hit, gen, tally);
endinterface : selfid_track_if
`default_nettype wire

// ===== hw/selfid_tracker.sv
`timescale 1ns/100ps
`default_nettype none
module selfid_tracker
  import selfid_pkg::*;
(
  input wire logic     clk,
  input wire logic     rst_n,
  selfid_track_if.tracker trk
);
  tracker_state_type s_q;  // Registered state
  tracker_state_type s_d;  // Next state

  // Status fields straight from the state
  assign trk.fault     = s_q.fault;
  assign trk.receiving = s_q.receiving;
  assign trk.gen       = s_q.gen;
  assign trk.tally     = s_q.tally;
  assign trk.err_hit   = s_q.receiving & trk.rx_err & ~trk.rx_start;
  assign trk.done_hit  = s_q.receiving & trk.rx_done & ~trk.rx_start;

  // Next state of the tracker
  always_comb begin
    s_d = s_q;
    if (trk.bus_reset) begin
      s_d.gen = s_q.gen + `GEN_W'(1);  // RULE5 RULE6
    end
    if (trk.rx_start) begin
      // New round: count from zero, forget old errors
      s_d.receiving = 1'b1;
      s_d.err_seen  = 1'b0;
      s_d.tally     = `QUAD_RESET;  // RULE8
    end else if (s_q.receiving) begin
      if (trk.rx_quad && s_q.tally != `QUAD_MAX) begin
        s_d.tally = s_q.tally + `QUAD_W'(1);  // RULE7
      end
      if (trk.rx_err) begin
        s_d.err_seen = 1'b1;
        s_d.fault    = 1'b1;  // RULE1 RULE4
      end
      if (trk.rx_done) begin
        s_d.receiving = 1'b0;
        // An error in the closing cycle still wins
        if (!s_q.err_seen && !trk.rx_err) begin
          s_d.fault = 1'b0;  // RULE3
        end
      end
    end
  end

  // State register, synchronous reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '{fault: 1'b0, err_seen: 1'b0, receiving: 1'b0,
               gen: `GEN_RESET, tally: `QUAD_RESET};
    end else begin
      s_q <= s_d;
    end
  end

  chk_gen_step: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
    trk.bus_reset |=> s_q.gen == $past(s_q.gen) + `GEN_W'(1))
    else $error("bus reset tally did not step");
  chk_gen_wrap: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
    trk.bus_reset && s_q.gen == 8'hFF |=> s_q.gen == 8'h00)
    else $error("bus reset tally did not wrap");
  chk_fault_set: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
    trk.err_hit |=> s_q.fault)
    else $error("fault flag not set on error");
  chk_fault_clear: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
    trk.done_hit && !s_q.err_seen && !trk.rx_err |=> !s_q.fault)
    else $error("fault flag not cleared on clean end");
  chk_tally_zero: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
    trk.rx_start |=> s_q.tally == `QUAD_RESET)
    else $error("quadlet tally not zeroed at start");
  chk_tally_step: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
    s_q.receiving && trk.rx_quad && !trk.rx_start && s_q.tally != `QUAD_MAX
    |=> s_q.tally == $past(s_q.tally) + `QUAD_W'(1))
    else $error("quadlet tally did not count");
endmodule : selfid_tracker
`default_nettype wire

// ===== verif/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "selfid_params.svh"
module testbench
  import selfid_pkg::*;
;
  logic        mclk;      // Bench clock, 100 MHz
  logic        rst_n;     // Synchronous reset, active low
  logic [7:0]  addr;      // Register address
  logic [31:0] wdata;     // Write data
  logic        wr;        // Write strobe
  logic        rd;        // Read strobe
  logic [31:0] rdata;     // Read data
  logic [5:0]  evs;       // Event pulses, one bit per input
  logic        iso_v;     // Packet offered
  logic [5:0]  iso_ch;    // Offered channel
  logic        iso_acc;   // Packet accepted
  logic        buf_ok;    // Buffer usable
  logic        irq;       // Interrupt level
  int          n_errors;  // Mismatches seen
  int          n_checks;  // Comparisons made
  logic [7:0]  g;         // Expected bus reset tally
  logic [31:0] m;         // Expected channel mask

  // Device under test
  selfid_status_iso_mask_high dut (
    .MCLK(mclk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .BUS_RESET(evs[0]), .RX_START(evs[1]), .RX_QUAD(evs[2]),
    .RX_DONE(evs[3]), .RX_HW_ERR(evs[4]), .RX_HOST_ERR(evs[5]),
    .ISO_VALID(iso_v), .ISO_CHANNEL(iso_ch), .ISO_ACCEPT(iso_acc),
    .BUF_VALID(buf_ok), .IRQ(irq)
  );

  // Clock toggles every half period
  always #5 mclk = ~mclk;

  // Compare one value and count it
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Verdict and end of run
  task automatic results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  // One-cycle register write
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask : wr_reg

  // One-cycle read, data checked in the following cycle
  task automatic rd_reg(input string nm, input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    #1;
    chk(nm, rdata, exp);
    // Read data stand one cycle only, then fall back to zero
    @(posedge mclk);
    #1;
    chk(nm, rdata, 32'h0000_0000);
  endtask : rd_reg

  // One-cycle event pulse
  task automatic ev(input logic [5:0] v);
    @(posedge mclk);
    evs <= v;
    @(posedge mclk);
    evs <= 6'h00;
  endtask : ev

  // Reception of nq quadlets with an optional error pulse
  task automatic round(input int nq, input logic [5:0] err);
    ev(6'h02);
    repeat (nq) ev(6'h04);
    if (err != 6'h00) begin
      ev(err);
    end
    ev(6'h08);
  endtask : round

  // Expected status word
  function automatic logic [31:0] stat(input logic f, input logic [7:0] gg,
                                       input logic [8:0] q);
    return {f, 7'h00, gg, 5'h00, q, 2'h0};
  endfunction : stat

  // Hang guard
  initial begin
    #100000;
    n_errors++;
    results();
  end

  // Main sequence
  initial begin
    mclk = 1'b0; rst_n = 1'b0; addr = 8'h00; wdata = 32'h0000_0000;
    wr = 1'b0; rd = 1'b0; evs = 6'h00; iso_v = 1'b0; iso_ch = 6'h00;
    n_errors = 0; n_checks = 0; g = 8'h00; m = 32'h0000_0000;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    // Reset values and ignored status writes
    rd_reg("status", `OFF_NODE_REPORT, 32'h0000_0000);
    wr_reg(`OFF_NODE_REPORT, 32'hFFFF_FFFF);
    rd_reg("status", `OFF_NODE_REPORT, 32'h0000_0000);
    rd_reg("unmapped", 8'h10, 32'h0000_0000);
    chk("irq", irq, 32'h0);
    // Bus reset tally steps and wraps
    repeat (255) begin
      ev(6'h01);
      g = g + 8'h01;
    end
    rd_reg("status", `OFF_NODE_REPORT, stat(1'b0, 8'hFF, 9'h000));
    ev(6'h01);
    g = g + 8'h01;
    rd_reg("status", `OFF_NODE_REPORT, stat(1'b0, g, 9'h000));
    // Clean reception counts quadlets
    round(5, 6'h00);
    rd_reg("status", `OFF_NODE_REPORT, stat(1'b0, g, 9'h005));
    chk("buf_valid", buf_ok, 32'h1);
    // Start zeroes the count, hardware fault sets the flag
    ev(6'h02);
    rd_reg("status", `OFF_NODE_REPORT, stat(1'b0, g, 9'h000));
    ev(6'h04);
    ev(6'h10);
    ev(6'h08);
    rd_reg("status", `OFF_NODE_REPORT, stat(1'b1, g, 9'h001));
    chk("buf_valid", buf_ok, 32'h0);
    // Clean round clears the flag
    round(2, 6'h00);
    rd_reg("status", `OFF_NODE_REPORT, stat(1'b0, g, 9'h002));
    chk("buf_valid", buf_ok, 32'h1);
    // Host write failure also sets the flag
    round(1, 6'h20);
    rd_reg("status", `OFF_NODE_REPORT, stat(1'b1, g, 9'h001));
    // Events: raise, mask, clear
    rd_reg("ev_status", `OFF_EVENT_STATUS, 32'h0000_0007);
    chk("irq", irq, 32'h0);
    wr_reg(`OFF_EVENT_MASK, 32'h0000_0002);
    repeat (2) @(posedge mclk);
    #1;
    chk("irq", irq, 32'h1);
    wr_reg(`OFF_EVENT_STATUS, 32'h0000_0002);
    repeat (2) @(posedge mclk);
    #1;
    chk("irq", irq, 32'h0);
    rd_reg("ev_status", `OFF_EVENT_STATUS, 32'h0000_0005);
    rd_reg("ev_mask", `OFF_EVENT_MASK, 32'h0000_0002);
    // Mask set and clear, zeros keep
    wr_reg(`OFF_MASK_SET, 32'h8000_0011);
    wr_reg(`OFF_MASK_CLEAR, 32'h0000_0001);
    wr_reg(`OFF_MASK_SET, 32'h0000_0000);
    wr_reg(`OFF_MASK_CLEAR, 32'h0000_0000);
    m = 32'h8000_0010;
    rd_reg("mask_set", `OFF_MASK_SET, m);
    rd_reg("mask_clear", `OFF_MASK_CLEAR, m);
    // Every channel offered against the mask
    for (int c = 0; c < 64; c++) begin
      @(posedge mclk);
      iso_v  <= 1'b1;
      iso_ch <= 6'(c);
      @(posedge mclk);
      iso_v  <= 1'b0;
      #1;
      chk("iso_accept", iso_acc, (c >= 32) ? 32'(m[c-32]) : 32'h0);
    end
    // All enables set, channel 31 still refused, channel 32 accepted
    wr_reg(`OFF_MASK_SET, 32'hFFFF_FFFF);
    for (int c = 31; c < 33; c++) begin
      @(posedge mclk);
      iso_v  <= 1'b1;
      iso_ch <= 6'(c);
      @(posedge mclk);
      iso_v  <= 1'b0;
      #1;
      chk("iso_accept", iso_acc, (c >= 32) ? 32'h1 : 32'h0);
    end
    // Reset in mid-run returns the fields and the gate to zero
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    chk("iso_accept", iso_acc, 32'h0);
    rd_reg("status", `OFF_NODE_REPORT, 32'h0000_0000);
    rd_reg("mask_set", `OFF_MASK_SET, 32'h0000_0000);
    results();
  end
endmodule : testbench
`default_nettype wire
